// *** include/host_port_pkg.sv ***
package host_port_pkg;

   typedef enum logic [1:0]
   {
      ACC_CTRL = 2'b00,
      ACC_DATA_INC = 2'b01,
      ACC_PTR = 2'b10,
      ACC_DATA = 2'b11
   } access_sel_type;

   typedef enum logic [1:0]
   {
      HP_IDLE = 2'b00,
      HP_BUSY = 2'b01,
      HP_HOLD = 2'b10
   } host_state_type;

   typedef enum logic [1:0]
   {
      BK_NONE = 2'b00,
      BK_CTRL = 2'b01,
      BK_MEM = 2'b10,
      BK_BAD = 2'b11
   } bus_kind_type;

endpackage

// *** include/host_port_regs.svh ***
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// Core-side bus map (byte addresses)
`define CTRL_OFF 32'h0000_0000
`define MEM_BASE 32'h0000_2000
`define MEM_SPAN 32'h0000_2000
// Shared memory geometry
`define MEM_WORDS 2048
`define MEM_WIDTH 16
// Control word fields
`define CTRL_ORDER_BIT 0
`define CTRL_CORE_IRQ_BIT 1
`define CTRL_HOST_IRQ_BIT 2
`define CTRL_RESET 16'h0000
// Core clock periods per host byte
`define BYTE_CYCLES 5
// Host data bus
`define HOST_BYTE 8

`endif

// *** sim/host_model.sv ***
module host_model
(
   // Clock
   input wire clock_i,
   // Device answers
   input wire ready_i,
   input wire [7:0] dev_data_i,
   input wire [7:0] dev_oe_i,
   // Host strobes and fields
   output logic select_n_o,
   output logic strobe_a_o,
   output logic strobe_b_o,
   output logic addr_strobe_n_o,
   output logic read_write_o,
   output logic ident_o,
   output host_port_pkg::access_sel_type access_o,
   // Resolved pin level
   output logic [7:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wdata;
   logic [7:0] last;
   logic drive;

   // Floating bus toggles so stale data never passes
   assign bus_o = (|dev_oe_i) ? dev_data_i : (drive ? wdata : ~last);
   always @(posedge clock_i)
      last <= bus_o;

   initial
   begin
      select_n_o = 1'b1;
      strobe_a_o = 1'b1;
      strobe_b_o = 1'b1;
      addr_strobe_n_o = 1'b1;
      read_write_o = 1'b1;
      ident_o = 1'b0;
      access_o = host_port_pkg::ACC_CTRL;
      drive = 1'b0;
      wdata = 8'h00;
   end

   // Mode 0 strobes and select together, 1 address strobe, 2 select last
   task automatic xfer(input logic [1:0] sel, input logic rw, input logic id, input logic [7:0] wb,
                       input int mode, output logic [7:0] rb, output int n);
      logic pol;
      pol = 1'($urandom_range(0, 1));
      read_write_o <= rw;
      ident_o <= id;
      access_o <= host_port_pkg::access_sel_type'(sel);
      drive <= ~rw;
      wdata <= wb;
      if (mode == 1)
      begin
         addr_strobe_n_o <= 1'b0;
         @(posedge clock_i);
         addr_strobe_n_o <= 1'b1;
         access_o <= host_port_pkg::access_sel_type'(~sel);
         ident_o <= ~id;
         read_write_o <= ~rw;
      end
      strobe_a_o <= pol;
      strobe_b_o <= ~pol;
      if (mode == 2)
         @(posedge clock_i);
      select_n_o <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (ready_i !== 1'b1 && n < 64);
      rb = bus_o;
      select_n_o <= 1'b1;
      strobe_a_o <= 1'b1;
      strobe_b_o <= 1'b1;
      drive <= 1'b0;
      @(posedge clock_i);
   endtask
endmodule // host_model

// *** sim/testbench.sv ***
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import host_port_pkg::*;
   localparam int BYTE_CYC = 5;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic interface_select_i = 1'b1;
   logic sel_n, sa, sb, as_n, rw, ident;
   access_sel_type acc;
   logic [7:0] bus, dout, doe, ser_i, ser_oe, ser_o;
   logic rdy, host_interrupt_out_n, core_irq;
   logic [31:0] haddr_i = 32'h0000_0000;
   logic [1:0] htrans_i = 2'b00;
   logic hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0000_0000;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o;
   int error_cnt = 0;
   int check_count = 0;
   logic [15:0] mem [0:2047];
   int ptr, mcnt, p, i, k;
   logic order, cirq, hirq;
   logic [15:0] rd16;
   logic [31:0] rd;

   always #5 clock_i = ~clock_i;

   host_port #(.BYTE_CYCLES(BYTE_CYC), .MEM_WORDS(2048)) i_host_port (
      .clock_i(clock_i), .rstn_i(rstn_i), .interface_select_i(interface_select_i),
      .port_select_n_i(sel_n), .data_strobe_a_i(sa), .data_strobe_b_i(sb), .addr_strobe_n_i(as_n),
      .host_read_write_i(rw), .byte_order_ident_i(ident), .access_select_i(acc),
      .host_data_bus_i(bus), .host_data_bus_o(dout), .host_data_bus_oe_o(doe),
      .port_ready_out_o(rdy), .host_interrupt_out_n_o(host_interrupt_out_n),
      .serial_lines_i(ser_i), .serial_lines_oe_i(ser_oe), .serial_lines_o(ser_o), .core_irq_o(core_irq),
      .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010),
      .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o));

   host_model i_host_model (
      .clock_i(clock_i), .ready_i(rdy), .dev_data_i(dout), .dev_oe_i(doe), .select_n_o(sel_n),
      .strobe_a_o(sa), .strobe_b_o(sb), .addr_strobe_n_o(as_n), .read_write_o(rw), .ident_o(ident),
      .access_o(acc), .bus_o(bus));

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (hreadyout_o !== 1'b1 && n < 64);
      if (n >= 64)
      begin
         error_cnt++;
         final_report();
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
      htrans_i <= 2'b10;
      haddr_i <= a;
      hwrite_i <= wr;
      wait_ready();
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      wait_ready();
      r = hrdata_o;
   endtask

   task automatic irq_chk();
      @(posedge clock_i);
      `CHK(core_irq, cirq)
      `CHK(host_interrupt_out_n, ~hirq)
   endtask

   task automatic core_wr(input int idx, input logic [31:0] wd);
      logic [31:0] r;
      if (idx < 0)
      begin
         ahb(1'b1, 32'h0000_0000, wd, r);
         order = wd[0];
         if (wd[1])
            cirq = 1'b0;
         if (wd[2])
            hirq = 1'b1;
         irq_chk();
      end
      else
      begin
         ahb(1'b1, 32'h0000_2000 + 32'(idx) * 4, wd, r);
         mem[idx] = wd[15:0];
      end
   endtask

   task automatic core_chk(input int idx);
      logic [31:0] r;
      ahb(1'b0, 32'h0000_2000 + 32'(idx) * 4, 32'h0000_0000, r);
      `CHK(r, {16'h0000, mem[idx]})
      `CHK(hresp_o, 1'b0)
   endtask

   task automatic hword(input access_sel_type sel, input logic w_n, input logic [15:0] w);
      logic [7:0] r0, r1;
      logic [15:0] rw16;
      int n, mode;
      mode = mcnt % 3;
      mcnt++;
      i_host_model.xfer(sel, w_n, 1'b0, order ? w[15:8] : w[7:0], mode, r0, n);
      `CHK(n, BYTE_CYC + 1)
      if (n >= 64)
         final_report();
      i_host_model.xfer(sel, w_n, 1'b1, order ? w[7:0] : w[15:8], mode, r1, n);
      `CHK(n, BYTE_CYC + 1)
      if (n >= 64)
         final_report();
      rw16 = order ? {r0, r1} : {r1, r0};
      if (sel == ACC_PTR && w_n)
         `CHK(rw16, 16'(ptr))
      else if (sel == ACC_PTR)
         ptr = w & 2047;
      else if (sel == ACC_CTRL && w_n)
         `CHK(rw16[2:0], {hirq, cirq, order})
      else if (sel == ACC_CTRL)
      begin
         order = w[0];
         if (w[1])
            cirq = 1'b1;
         if (w[2])
            hirq = 1'b0;
         irq_chk();
      end
      else
      begin
         if (sel == ACC_DATA_INC && !w_n)
            ptr = (ptr + 1) & 2047;
         if (w_n)
            `CHK(rw16, mem[ptr])
         else
            mem[ptr] = w;
         if (sel == ACC_DATA_INC && w_n)
            ptr = (ptr + 1) & 2047;
      end
   endtask

   initial
   begin
      void'($urandom(79));
      ser_i = 8'h00;
      ser_oe = 8'h00;
      order = 1'b0;
      cirq = 1'b0;
      hirq = 1'b0;
      ptr = 0;
      mcnt = 0;
      repeat (8) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
      `CHK(rd[2:0], 3'b000)
      ahb(1'b0, 32'h0000_1000, 32'h0000_0000, rd);
      `CHK(rd, 32'h0000_0000)
      for (i = 0; i < 2; i++)
      begin
         hword(ACC_CTRL, 1'b0, 16'(i));
         p = $urandom_range(0, 2047);
         hword(ACC_PTR, 1'b0, 16'(p));
         hword(ACC_PTR, 1'b1, 16'h0000);
         for (k = 0; k < 8; k++)
            core_wr((p + k) & 2047, $urandom);
         repeat (3) hword(ACC_DATA_INC, 1'b0, 16'($urandom));
         hword(ACC_DATA, 1'b0, 16'($urandom));
         for (k = 0; k < 8; k++)
            core_chk((p + k) & 2047);
         hword(ACC_PTR, 1'b0, 16'(p));
         repeat (5) hword(ACC_DATA_INC, 1'b1, 16'h0000);
         hword(ACC_DATA, 1'b1, 16'h0000);
         hword(ACC_PTR, 1'b1, 16'h0000);
         core_wr(-1, {29'h0, 3'b100} | 32'(order));
         hword(ACC_CTRL, 1'b0, 16'h0006 | 16'(order));
         hword(ACC_CTRL, 1'b1, 16'h0000);
         core_wr(-1, {29'h0, 3'b010} | 32'(order));
      end
      rstn_i <= 1'b0;
      interface_select_i <= 1'b0;
      ser_i <= 8'($urandom);
      ser_oe <= 8'($urandom) | 8'h01;
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      `CHK(dout, ser_i)
      `CHK(doe, ser_oe)
      `CHK(ser_o, ser_i)
      `CHK(rdy, 1'b0)
      final_report();
   end
endmodule // testbench

// *** src/host_port.sv ***
// Functional notes
// - Interface select sampled at reset release
// - Shared 2K-word memory, host and core
// - Host wins contention, core stalls
// - Word moves as two ordered bytes
// - Control bit picks which byte is high
// - Access select picks one of four targets
// - Read postincrements, write preincrements pointer
// - Pointer host-only, addresses data access
// - Control register shared by host, core
// - Data register host-only, holds memory word
// - Host control write interrupts core
// - Core raises host interrupt, host clears
// - Two strobes, read/write, address strobe
// - One byte every five core clocks
// - Ready low inserts host wait states
// - Address strobe fall latches access fields
// - Else later strobe or select latches
// - Data strobes combined by exclusive-NOR
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`include "host_port_regs.svh"

module host_port #(
   parameter int BYTE_CYCLES = `BYTE_CYCLES,
   parameter int MEM_WORDS = `MEM_WORDS
) (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Mode strap
   input wire interface_select_i,
   // Host strobes and address
   input wire port_select_n_i,
   input wire data_strobe_a_i,
   input wire data_strobe_b_i,
   input wire addr_strobe_n_i,
   input wire host_read_write_i,
   input wire byte_order_ident_i,
   input host_port_pkg::access_sel_type access_select_i,
   // Host data bus
   input wire [7:0] host_data_bus_i,
   output logic [7:0] host_data_bus_o,
   output logic [7:0] host_data_bus_oe_o,
   // Host handshake and interrupt
   output logic port_ready_out_o,
   output logic host_interrupt_out_n_o,
   // Serial-mode control lines
   input wire [7:0] serial_lines_i,
   input wire [7:0] serial_lines_oe_i,
   output logic [7:0] serial_lines_o,
   // Core interrupt
   output logic core_irq_o,
   // AHB-Lite slave
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire hready_i,
   input wire [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o
);
   import host_port_pkg::*;

   localparam int AW = $clog2(MEM_WORDS);
   localparam int CW = $clog2(BYTE_CYCLES);
   localparam logic [CW-1:0] CNT_LOAD = CW'(BYTE_CYCLES - 2);
   localparam logic [CW-1:0] CNT_FETCH = CW'(BYTE_CYCLES - 3);

   if (BYTE_CYCLES < 4 || MEM_WORDS < 2)
   begin : g_bad_param
      $error("host_port: byte period or memory size too small");
   end

   // Mode and control state
   logic mode_done_r, mode_done_nxt;
   logic parallel_r, parallel_nxt;
   logic order_r, order_nxt;
   logic core_irq_r, core_irq_nxt;
   logic host_irq_r, host_irq_nxt;
   logic [7:0] serial_r, serial_nxt;
   logic [15:0] ctrl_word;
   // Host port state
   host_state_type hstate_r, hstate_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   access_sel_type sel_r, sel_nxt;
   logic rd_r, rd_nxt;
   logic second_r, second_nxt;
   logic has_lat_r, has_lat_nxt;
   access_sel_type has_sel_r, has_sel_nxt;
   logic has_rd_r, has_rd_nxt;
   logic has_bil_r, has_bil_nxt;
   logic active_prev_r, has_prev_r;
   logic [7:0] stage_r, stage_nxt;
   logic [15:0] word_r, word_nxt;
   logic [7:0] out_byte_r, out_byte_nxt;
   logic [AW-1:0] ptr_r, ptr_nxt;
   logic active, start, has_fall, finish, is_data, autoinc, hi_byte;
   logic [15:0] wr_word;
   // Memory ports
   logic host_en, host_we;
   logic [AW-1:0] host_addr;
   logic [15:0] host_rdata, core_rdata;
   logic core_en, core_stall;
   // Bus state
   logic dp_valid_r, dp_valid_nxt;
   logic dp_write_r, dp_write_nxt;
   bus_kind_type dp_kind_r, dp_kind_nxt;
   logic [AW-1:0] dp_word_r, dp_word_nxt;
   logic rd_wait_r, rd_wait_nxt;
   logic acc;
   logic core_ctrl_wr, host_ctrl_wr;
   logic [31:0] mem_off;

   assign active = parallel_r & ~port_select_n_i & ~(data_strobe_a_i ~^ data_strobe_b_i);
   // Later of strobe or select starts
   assign start = active & ~active_prev_r & (hstate_r == HP_IDLE);
   assign has_fall = parallel_r & has_prev_r & ~addr_strobe_n_i;
   assign finish = (hstate_r == HP_BUSY) && (cnt_r == '0);
   assign is_data = (sel_r == ACC_DATA_INC) || (sel_r == ACC_DATA);
   assign autoinc = (sel_r == ACC_DATA_INC);
   // Order bit maps first byte high
   assign hi_byte = order_r ? ~second_r : second_r;
   assign wr_word = order_r ? {stage_r, host_data_bus_i} : {host_data_bus_i, stage_r};
   assign host_ctrl_wr = finish & ~rd_r & second_r & (sel_r == ACC_CTRL);

   // Fetch for first data read byte
   assign host_en = ((hstate_r == HP_BUSY) && (cnt_r == CNT_LOAD) && rd_r && is_data && !second_r)
      | host_we;
   // Memory written only on second byte
   assign host_we = finish & ~rd_r & second_r & is_data;
   assign host_addr = (host_we & autoinc) ? AW'(ptr_r + 1'b1) : ptr_r;

   always_comb
   begin
      ctrl_word = `CTRL_RESET;
      ctrl_word[`CTRL_ORDER_BIT] = order_r;
      ctrl_word[`CTRL_CORE_IRQ_BIT] = core_irq_r;
      ctrl_word[`CTRL_HOST_IRQ_BIT] = host_irq_r;
   end

   // Mode and control register next state
   always_comb
   begin
      mode_done_nxt = 1'b1;
      // Strap taken on first edge after release
      parallel_nxt = mode_done_r ? parallel_r : interface_select_i;
      serial_nxt = parallel_r ? 8'h00 : host_data_bus_i;
      order_nxt = order_r;
      // Both sides write control, host first
      if (host_ctrl_wr)
      begin
         order_nxt = wr_word[`CTRL_ORDER_BIT];
      end
      else if (core_ctrl_wr)
      begin
         order_nxt = hwdata_i[`CTRL_ORDER_BIT];
      end
      // Host sets, core clears, set wins
      core_irq_nxt = (host_ctrl_wr & wr_word[`CTRL_CORE_IRQ_BIT])
         | (core_irq_r & ~(core_ctrl_wr & hwdata_i[`CTRL_CORE_IRQ_BIT]));
      // Core sets, host acknowledges, set wins
      host_irq_nxt = (core_ctrl_wr & hwdata_i[`CTRL_HOST_IRQ_BIT])
         | (host_irq_r & ~(host_ctrl_wr & wr_word[`CTRL_HOST_IRQ_BIT]));
   end

   // Host byte engine next state
   always_comb
   begin
      hstate_nxt = hstate_r;
      cnt_nxt = cnt_r;
      sel_nxt = sel_r;
      rd_nxt = rd_r;
      second_nxt = second_r;
      has_lat_nxt = has_lat_r;
      has_sel_nxt = has_sel_r;
      has_rd_nxt = has_rd_r;
      has_bil_nxt = has_bil_r;
      stage_nxt = stage_r;
      word_nxt = word_r;
      out_byte_nxt = out_byte_r;
      ptr_nxt = ptr_r;
      if (has_fall)
      begin
         has_lat_nxt = 1'b1;
         has_sel_nxt = access_select_i;
         has_rd_nxt = host_read_write_i;
         has_bil_nxt = byte_order_ident_i;
      end
      case (hstate_r)
         HP_IDLE:
         begin
            if (start)
            begin
               sel_nxt = has_lat_r ? has_sel_r : access_select_i;
               rd_nxt = has_lat_r ? has_rd_r : host_read_write_i;
               second_nxt = has_lat_r ? has_bil_r : byte_order_ident_i;
               has_lat_nxt = has_fall;
               cnt_nxt = CNT_LOAD;
               hstate_nxt = HP_BUSY;
            end
         end
         HP_BUSY:
         begin
            cnt_nxt = CW'(cnt_r - 1'b1);
            if (cnt_r == CNT_FETCH && rd_r && !second_r)
            begin
               case (sel_r)
                  ACC_CTRL: word_nxt = ctrl_word;
                  ACC_PTR: word_nxt = 16'(ptr_r);
                  default: word_nxt = host_rdata;
               endcase
            end
            if (finish)
            begin
               hstate_nxt = HP_HOLD;
               if (rd_r)
               begin
                  out_byte_nxt = hi_byte ? word_r[15:8] : word_r[7:0];
                  if (second_r && autoinc)
                  begin
                     ptr_nxt = AW'(ptr_r + 1'b1);
                  end
               end
               else if (!second_r)
               begin
                  stage_nxt = host_data_bus_i;
               end
               else
               begin
                  if (sel_r == ACC_PTR)
                  begin
                     ptr_nxt = wr_word[AW-1:0];
                  end
                  if (is_data)
                  begin
                     word_nxt = wr_word;
                  end
                  if (autoinc)
                  begin
                     ptr_nxt = AW'(ptr_r + 1'b1);
                  end
               end
            end
         end
         HP_HOLD:
         begin
            if (!active)
            begin
               hstate_nxt = HP_IDLE;
            end
         end
         default:
         begin
            hstate_nxt = HP_IDLE;
         end
      endcase
   end

   // Core bus decode
   assign acc = hsel_i & htrans_i[1] & hready_i;
   assign mem_off = haddr_i - `MEM_BASE;
   assign core_en = dp_valid_r & (dp_kind_r == BK_MEM) & ~rd_wait_r;
   assign core_ctrl_wr = dp_valid_r & dp_write_r & (dp_kind_r == BK_CTRL);

   always_comb
   begin
      // Stalled core access waits one cycle
      hreadyout_o = ~dp_valid_r | (dp_kind_r != BK_MEM) | rd_wait_r | (dp_write_r & ~core_stall);
      hresp_o = 1'b0;
      case (dp_kind_r)
         BK_CTRL: hrdata_o = 32'(ctrl_word);
         BK_MEM: hrdata_o = 32'(core_rdata);
         default: hrdata_o = 32'h0000_0000;
      endcase
      dp_valid_nxt = dp_valid_r & ~hreadyout_o;
      dp_write_nxt = dp_write_r;
      dp_kind_nxt = hreadyout_o ? BK_NONE : dp_kind_r;
      dp_word_nxt = dp_word_r;
      // Read data returns one cycle after issue
      rd_wait_nxt = core_en & ~dp_write_r & ~core_stall;
      if (acc)
      begin
         dp_valid_nxt = 1'b1;
         dp_write_nxt = hwrite_i;
         dp_word_nxt = AW'(mem_off >> 2);
         if (haddr_i >= `MEM_BASE && haddr_i < `MEM_BASE + `MEM_SPAN)
         begin
            dp_kind_nxt = BK_MEM;
         end
         else if (haddr_i == `CTRL_OFF)
         begin
            dp_kind_nxt = BK_CTRL;
         end
         else
         begin
            dp_kind_nxt = BK_BAD;
         end
      end
   end

   // Shared block reached from both sides
   shared_word_mem #(
      .DEPTH(MEM_WORDS),
      .WIDTH(`MEM_WIDTH),
      .AW(AW)
   ) u_mem (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .host_en_i(host_en),
      .host_we_i(host_we),
      .host_addr_i(host_addr),
      .host_wdata_i(wr_word),
      .host_rdata_o(host_rdata),
      .core_en_i(core_en),
      .core_we_i(dp_write_r),
      .core_addr_i(dp_word_r),
      .core_wdata_i(hwdata_i[15:0]),
      .core_rdata_o(core_rdata),
      .core_stall_o(core_stall)
   );

   // Ready low while byte in progress
   assign port_ready_out_o = parallel_r & ~start & (hstate_r != HP_BUSY);
   assign host_data_bus_oe_o = parallel_r ? {8{active & rd_r & (hstate_r != HP_IDLE)}} : serial_lines_oe_i;
   assign host_data_bus_o = parallel_r ? out_byte_r : serial_lines_i;
   assign host_interrupt_out_n_o = ~(host_irq_r & parallel_r);
   assign core_irq_o = core_irq_r;
   assign serial_lines_o = serial_r;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mode_done_r <= 1'b0;
         parallel_r <= 1'b0;
         order_r <= 1'b0;
         core_irq_r <= 1'b0;
         host_irq_r <= 1'b0;
         serial_r <= 8'h00;
         hstate_r <= HP_IDLE;
         cnt_r <= '0;
         sel_r <= ACC_CTRL;
         rd_r <= 1'b0;
         second_r <= 1'b0;
         has_lat_r <= 1'b0;
         has_sel_r <= ACC_CTRL;
         has_rd_r <= 1'b0;
         has_bil_r <= 1'b0;
         active_prev_r <= 1'b0;
         has_prev_r <= 1'b1;
         stage_r <= 8'h00;
         word_r <= 16'h0000;
         out_byte_r <= 8'h00;
         ptr_r <= '0;
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_kind_r <= BK_NONE;
         dp_word_r <= '0;
         rd_wait_r <= 1'b0;
      end
      else
      begin
         mode_done_r <= mode_done_nxt;
         parallel_r <= parallel_nxt;
         order_r <= order_nxt;
         core_irq_r <= core_irq_nxt;
         host_irq_r <= host_irq_nxt;
         serial_r <= serial_nxt;
         hstate_r <= hstate_nxt;
         cnt_r <= cnt_nxt;
         sel_r <= sel_nxt;
         rd_r <= rd_nxt;
         second_r <= second_nxt;
         has_lat_r <= has_lat_nxt;
         has_sel_r <= has_sel_nxt;
         has_rd_r <= has_rd_nxt;
         has_bil_r <= has_bil_nxt;
         active_prev_r <= active;
         has_prev_r <= addr_strobe_n_i;
         stage_r <= stage_nxt;
         word_r <= word_nxt;
         out_byte_r <= out_byte_nxt;
         ptr_r <= ptr_nxt;
         dp_valid_r <= dp_valid_nxt;
         dp_write_r <= dp_write_nxt;
         dp_kind_r <= dp_kind_nxt;
         dp_word_r <= dp_word_nxt;
         rd_wait_r <= rd_wait_nxt;
      end
   end

   chk_byte_period: assert property (@(posedge clock_i) disable iff (!rstn_i)
      start |-> !port_ready_out_o [*5] ##1 port_ready_out_o)
      else $error("byte period not five clocks");
   chk_xnor_start: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (parallel_r && !port_select_n_i && (data_strobe_a_i != data_strobe_b_i) && !active_prev_r
       && hstate_r == HP_IDLE) |-> !port_ready_out_o ##1 hstate_r == HP_BUSY)
      else $error("one-low strobe pair not accepted");
   chk_mode_strap: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(mode_done_r) |-> parallel_r == $past(interface_select_i))
      else $error("mode strap not taken at release");
   chk_serial_quiet: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !parallel_r |-> !port_ready_out_o && host_hstate_idle())
      else $error("host port active in serial mode");
   chk_post_inc: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (finish && rd_r && second_r && autoinc) |=> ptr_r == AW'($past(ptr_r) + 1'b1))
      else $error("read did not postincrement");
   chk_pre_inc: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (host_we && autoinc) |-> host_addr == AW'(ptr_r + 1'b1) ##1 ptr_r == $past(host_addr))
      else $error("write did not preincrement");
   chk_core_stall: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (host_en && core_en && host_addr == dp_word_r) |-> !hreadyout_o)
      else $error("core not stalled on contention");
   chk_host_interrupt_out_ack: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (host_ctrl_wr && wr_word[`CTRL_HOST_IRQ_BIT] && !core_ctrl_wr) |=> host_interrupt_out_n_o)
      else $error("host interrupt not cleared");
   chk_has_latch: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (start && has_lat_r) |=> sel_r == $past(has_sel_r) && rd_r == $past(has_rd_r))
      else $error("strobe-latched fields not used");
   chk_pair_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
      host_we |-> second_r && !rd_r && finish)
      else $error("memory written outside second byte");

   function automatic logic host_hstate_idle();
      return hstate_r == HP_IDLE;
   endfunction

endmodule // host_port

// *** src/shared_word_mem.sv ***
module shared_word_mem #(
   parameter int DEPTH = 2048,
   parameter int WIDTH = 16,
   parameter int AW = 11
) (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Host side, always wins
   input wire host_en_i,
   input wire host_we_i,
   input wire [AW-1:0] host_addr_i,
   input wire [WIDTH-1:0] host_wdata_i,
   output logic [WIDTH-1:0] host_rdata_o,
   // Core side
   input wire core_en_i,
   input wire core_we_i,
   input wire [AW-1:0] core_addr_i,
   input wire [WIDTH-1:0] core_wdata_i,
   output logic [WIDTH-1:0] core_rdata_o,
   output logic core_stall_o
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] host_rdata_nxt;
   logic [WIDTH-1:0] core_rdata_nxt;
   logic core_go;

   if (DEPTH > (1 << AW) || DEPTH < 2)
   begin : g_bad_depth
      $error("shared_word_mem: depth does not fit address width");
   end

   assign core_stall_o = host_en_i & core_en_i & (host_addr_i == core_addr_i);
   assign core_go = core_en_i & ~core_stall_o;

   always_comb
   begin
      host_rdata_nxt = host_rdata_o;
      core_rdata_nxt = core_rdata_o;
      if (host_en_i & ~host_we_i)
      begin
         host_rdata_nxt = mem[host_addr_i];
      end
      if (core_go & ~core_we_i)
      begin
         core_rdata_nxt = mem[core_addr_i];
      end
   end

   // Array kept out of reset so it maps to RAM
   always_ff @(posedge clock_i)
   begin
      if (host_en_i & host_we_i)
      begin
         mem[host_addr_i] <= host_wdata_i;
      end
      if (core_go & core_we_i)
      begin
         mem[core_addr_i] <= core_wdata_i;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         host_rdata_o <= '0;
         core_rdata_o <= '0;
      end
      else
      begin
         host_rdata_o <= host_rdata_nxt;
         core_rdata_o <= core_rdata_nxt;
      end
   end

endmodule // shared_word_mem
